// file: include/pkaf_pkg.sv
// shared types and constants for the subscriber-side authorization machine
// assumes one 50 MHz clock and message decode/encode outside this block
// How it works
// - request traffic key before its expiry
// - reauthorize before authorization key expires
// - parent sends stop/authorized/pending/complete to children
// - auth invalid handled by parent machine
// - start on command, send maker cert first
// - then send request with id, key, cert
// - resend request when reply timer expires
// - new key usable only after reply timer
// - non-permanent reject triggers new request
// - periodic self-started request without maker cert
// - reauth request resent on request timer
// - keep authorization valid while reauth replies keep arriving
// - launch traffic-key machine for delivered id
// - reject during reauth stops all children
`default_nettype none
package pkaf_pkg;
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned REPLY_WAIT_MS   = 10;
    localparam int unsigned REAUTH_REQ_MS   = 10;
    localparam int unsigned REPLY_WAIT_CYC  = CLK_HZ / 1000 * REPLY_WAIT_MS;
    localparam int unsigned REAUTH_REQ_CYC  = CLK_HZ / 1000 * REAUTH_REQ_MS;
    localparam int unsigned LEAD_CYC        = 1000;
    localparam int unsigned LIFE_W          = 32;
    localparam int unsigned SECURITY_ASSOC_ID_W          = 16;
    localparam int unsigned SEQ_W           = 2;
    localparam int unsigned TMR_W           = 32;

    typedef enum logic [2:0] {
        PKAF_START      = 3'h0,
        PKAF_AUTH_WAIT  = 3'h1,
        PKAF_AUTHORIZED = 3'h2,
        PKAF_REAUTH     = 3'h3,
        PKAF_REJ_WAIT   = 3'h4,
        PKAF_SILENT     = 3'h5
    } pkaf_state_e;

    typedef struct packed {
        logic              valid;
        logic [SEQ_W-1:0]  seq;
        logic [LIFE_W-1:0] lifetime;
        logic [SECURITY_ASSOC_ID_W-1:0] security_assoc_id;
    } pkaf_reply_s;

    typedef struct packed {
        logic stop;
        logic authorized;
        logic pending;
        logic complete;
    } pkaf_child_ev_s;
endpackage
`default_nettype wire

// file: rtl/pkaf_timer.sv
// down-counting timer with load and expiry pulse
// assumes load and period on the same clock
`default_nettype none
module pkaf_timer #(
    parameter int unsigned W = 32
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         load,
    input  wire logic         stop,
    input  wire logic [W-1:0] period,
    output logic              expired
);
    typedef struct packed {
        logic         run;
        logic [W-1:0] cnt;
        logic         exp;
    } pkaf_tmr_s;
    pkaf_tmr_s s_q;
    pkaf_tmr_s s_d;

    always_comb begin
        s_d     = s_q;
        s_d.exp = 1'b0;
        // a load in the same cycle as a stop restarts the timer
        if (load) begin
            s_d.run = 1'b1;
            s_d.cnt = period;
        end else if (stop) begin
            s_d.run = 1'b0;
        end else if (s_q.run) begin
            if (s_q.cnt <= W'(1)) begin
                s_d.run = 1'b0;
                s_d.exp = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt - W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign expired = s_q.exp;
endmodule
`default_nettype wire

// file: rtl/pkaf_auth_fsm.sv
// subscriber-side authorization machine with key lifetime tracking
// assumes message receive strobes are one-cycle pulses on CLOCK
`default_nettype none
module pkaf_auth_fsm #(
    parameter int unsigned REPLY_WAIT = pkaf_pkg::REPLY_WAIT_CYC,
    parameter int unsigned REAUTH_REQ = pkaf_pkg::REAUTH_REQ_CYC,
    parameter int unsigned LEAD       = pkaf_pkg::LEAD_CYC
) (
    input  wire logic                        CLOCK,
    input  wire logic                        RESET,
    input  wire logic                        RX_AUTH_CMD,
    input  wire pkaf_pkg::pkaf_reply_s       RX_AUTH_REPLY,
    input  wire logic                        RX_AUTH_REJECT,
    input  wire logic                        RX_REJECT_PERM,
    input  wire logic                        RX_AUTH_INVALID,
    input  wire logic                        RX_KEY_GRANT,
    input  wire logic [pkaf_pkg::LIFE_W-1:0] RX_KEY_LIFE,
    output      logic                        TX_MAKER_CERT,
    output      logic                        TX_AUTH_REQ,
    output      logic                        TX_KEY_REQ,
    output var  pkaf_pkg::pkaf_child_ev_s    CHILD_EV,
    output      logic                        CHILD_RUN,
    output      logic [pkaf_pkg::SECURITY_ASSOC_ID_W-1:0] CHILD_SECURITY_ASSOC_ID,
    output      logic                        KEY_USABLE,
    output      logic [pkaf_pkg::SEQ_W-1:0]  KEY_SEQ,
    output var  pkaf_pkg::pkaf_state_e       STATE
);
    import pkaf_pkg::*;

    typedef struct packed {
        pkaf_state_e       st;
        logic              cert;
        logic              req;
        logic              kreq;
        pkaf_child_ev_s    ev;
        logic              run;
        logic [SECURITY_ASSOC_ID_W-1:0] security_assoc_id;
        logic [SEQ_W-1:0]  seq;
        logic              usable;
        logic              pend;
        logic [LIFE_W-1:0] ak_life;
        logic [LIFE_W-1:0] tk_life;
        logic              tk_on;
    } pkaf_st_s;

    pkaf_st_s s_q;
    pkaf_st_s s_d;
    logic     rep_exp;
    logic     req_exp;
    logic     rep_load;
    logic     req_load;

    function automatic logic near_end(input logic [LIFE_W-1:0] life);
        near_end = (life == LIFE_W'(LEAD));
    endfunction

    pkaf_timer #(.W(TMR_W)) u_reply (
        .clk     (CLOCK),
        .rst     (RESET),
        .load    (rep_load),
        .stop    (RX_AUTH_REPLY.valid),
        .period  (TMR_W'(REPLY_WAIT)),
        .expired (rep_exp)
    );

    pkaf_timer #(.W(TMR_W)) u_req (
        .clk     (CLOCK),
        .rst     (RESET),
        .load    (req_load),
        .stop    (RX_AUTH_REPLY.valid),
        .period  (TMR_W'(REAUTH_REQ)),
        .expired (req_exp)
    );

    always_comb begin
        s_d      = s_q;
        s_d.cert = 1'b0;
        s_d.req  = 1'b0;
        s_d.kreq = 1'b0;
        s_d.ev   = '0;
        rep_load = 1'b0;
        req_load = 1'b0;
        if (s_q.ak_life != '0) s_d.ak_life = s_q.ak_life - LIFE_W'(1);
        if (s_q.tk_life != '0) s_d.tk_life = s_q.tk_life - LIFE_W'(1);
        case (s_q.st)
            PKAF_START: begin
                if (RX_AUTH_CMD) begin
                    s_d.cert = 1'b1;
                    s_d.st   = PKAF_AUTH_WAIT;
                    s_d.pend = 1'b1;
                end
            end
            PKAF_AUTH_WAIT: begin
                if (s_q.pend) begin
                    s_d.req  = 1'b1;
                    s_d.pend = 1'b0;
                    rep_load = 1'b1;
                end else if (RX_AUTH_REPLY.valid) begin
                    s_d.st      = PKAF_AUTHORIZED;
                    s_d.security_assoc_id    = RX_AUTH_REPLY.security_assoc_id;
                    s_d.seq     = RX_AUTH_REPLY.seq;
                    s_d.ak_life = RX_AUTH_REPLY.lifetime;
                    s_d.run     = 1'b1;
                    s_d.ev.authorized = 1'b1;
                    s_d.usable  = 1'b0;
                    rep_load    = 1'b1;
                end else if (RX_AUTH_REJECT) begin
                    s_d.st = RX_REJECT_PERM ? PKAF_SILENT : PKAF_REJ_WAIT;
                end else if (rep_exp) begin
                    s_d.req  = 1'b1;
                    rep_load = 1'b1;
                end
            end
            PKAF_AUTHORIZED: begin
                if (RX_AUTH_INVALID || near_end(s_q.ak_life)) begin
                    s_d.st   = PKAF_REAUTH;
                    s_d.req  = 1'b1;
                    req_load = 1'b1;
                    s_d.ev.pending = 1'b1;
                end
            end
            PKAF_REAUTH: begin
                if (RX_AUTH_REPLY.valid) begin
                    s_d.st      = PKAF_AUTHORIZED;
                    s_d.seq     = RX_AUTH_REPLY.seq;
                    s_d.security_assoc_id    = RX_AUTH_REPLY.security_assoc_id;
                    s_d.ak_life = RX_AUTH_REPLY.lifetime;
                    s_d.usable  = 1'b0;
                    rep_load    = 1'b1;
                    s_d.ev.complete = 1'b1;
                end else if (RX_AUTH_REJECT) begin
                    s_d.run     = 1'b0;
                    s_d.ev.stop = 1'b1;
                    s_d.usable  = 1'b0;
                    s_d.st = RX_REJECT_PERM ? PKAF_SILENT : PKAF_REJ_WAIT;
                end else if (req_exp) begin
                    s_d.req  = 1'b1;
                    req_load = 1'b1;
                end
            end
            PKAF_REJ_WAIT: begin
                s_d.st   = PKAF_AUTH_WAIT;
                s_d.req  = 1'b1;
                rep_load = 1'b1;
            end
            PKAF_SILENT: begin
                s_d.st = PKAF_SILENT;
            end
            default: s_d.st = PKAF_START;
        endcase
        // an old timer expiry must not release a key delivered this cycle
        if ((s_q.st == PKAF_AUTHORIZED || s_q.st == PKAF_REAUTH) && rep_exp && !rep_load) begin
            s_d.usable = 1'b1;
        end
        if (RX_KEY_GRANT) begin
            s_d.tk_life = RX_KEY_LIFE;
            s_d.tk_on   = 1'b1;
        end else if (s_q.tk_on && s_q.run && near_end(s_q.tk_life)) begin
            s_d.kreq  = 1'b1;
            s_d.tk_on = 1'b0;
        end
        if (!s_d.run) s_d.tk_on = 1'b0;
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign TX_MAKER_CERT = s_q.cert;
    assign TX_AUTH_REQ   = s_q.req;
    assign TX_KEY_REQ    = s_q.kreq;
    assign CHILD_EV      = s_q.ev;
    assign CHILD_RUN     = s_q.run;
    assign CHILD_SECURITY_ASSOC_ID    = s_q.security_assoc_id;
    assign KEY_USABLE    = s_q.usable;
    assign KEY_SEQ       = s_q.seq;
    assign STATE         = s_q.st;

    property p_cert_then_req;
        @(posedge CLOCK) disable iff (RESET)
        TX_MAKER_CERT |=> TX_AUTH_REQ;
    endproperty
    a_cert_then_req: assert property (p_cert_then_req) else $error("no request after cert");

    property p_cmd_cert;
        @(posedge CLOCK) disable iff (RESET)
        (STATE == PKAF_START && RX_AUTH_CMD) |=> TX_MAKER_CERT;
    endproperty
    a_cmd_cert: assert property (p_cmd_cert) else $error("command not answered");

    property p_cert_only_cmd;
        @(posedge CLOCK) disable iff (RESET)
        TX_MAKER_CERT |-> $past(RX_AUTH_CMD);
    endproperty
    a_cert_only_cmd: assert property (p_cert_only_cmd) else $error("cert without command");

    property p_reject_stop;
        @(posedge CLOCK) disable iff (RESET)
        (STATE == PKAF_REAUTH && RX_AUTH_REJECT && !RX_AUTH_REPLY.valid)
            |=> CHILD_EV.stop && !CHILD_RUN;
    endproperty
    a_reject_stop: assert property (p_reject_stop) else $error("children not stopped");

    property p_nonperm_retry;
        @(posedge CLOCK) disable iff (RESET)
        (STATE == PKAF_AUTH_WAIT && RX_AUTH_REJECT && !RX_REJECT_PERM
            && !RX_AUTH_REPLY.valid && !TX_MAKER_CERT) |=> ##1 TX_AUTH_REQ;
    endproperty
    a_nonperm_retry: assert property (p_nonperm_retry) else $error("no retry after reject");

    property p_reply_launch;
        @(posedge CLOCK) disable iff (RESET)
        (STATE == PKAF_AUTH_WAIT && RX_AUTH_REPLY.valid && !TX_MAKER_CERT)
            |=> CHILD_RUN && CHILD_EV.authorized && CHILD_SECURITY_ASSOC_ID == $past(RX_AUTH_REPLY.security_assoc_id);
    endproperty
    a_reply_launch: assert property (p_reply_launch) else $error("child not launched");

    property p_not_usable_early;
        @(posedge CLOCK) disable iff (RESET)
        (STATE != PKAF_AUTHORIZED && STATE != PKAF_REAUTH) ##1 STATE == PKAF_AUTHORIZED
            |-> !KEY_USABLE;
    endproperty
    a_not_usable_early: assert property (p_not_usable_early) else $error("key used early");

    property p_invalid_reauth;
        @(posedge CLOCK) disable iff (RESET)
        (STATE == PKAF_AUTHORIZED && RX_AUTH_INVALID)
            |=> STATE == PKAF_REAUTH && TX_AUTH_REQ && CHILD_EV.pending;
    endproperty
    a_invalid_reauth: assert property (p_invalid_reauth) else $error("invalid not handled");

    property p_silent_quiet;
        @(posedge CLOCK) disable iff (RESET)
        STATE == PKAF_SILENT |=> !TX_AUTH_REQ && STATE == PKAF_SILENT;
    endproperty
    a_silent_quiet: assert property (p_silent_quiet) else $error("silent state left");
endmodule
`default_nettype wire

// file: test/pkaf_ap_model.sv
// access point model: answers auth requests, rejects, key grants
// assumes design pulses change on the rising edge; drives on falling edge
`default_nettype none
module pkaf_ap_model #(
    parameter int unsigned                 DLY     = 3,
    parameter int unsigned                 CMD_TMO = 100,
    parameter logic [pkaf_pkg::SECURITY_ASSOC_ID_W-1:0] SECURITY_ASSOC_ID    = 16'h0a5c,
    parameter logic [pkaf_pkg::LIFE_W-1:0] KLIFE   = 32'h0000001e
) (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic [1:0]                  mode,
    input  wire logic [pkaf_pkg::LIFE_W-1:0] ak_life,
    input  wire logic                        send_cmd,
    input  wire logic                        send_inval,
    input  wire logic                        send_grant,
    input  wire logic                        tx_cert,
    input  wire logic                        tx_req,
    input  wire logic                        tx_key_req,
    output      logic                        cmd,
    output var  pkaf_pkg::pkaf_reply_s       reply,
    output      logic                        reject,
    output      logic                        perm,
    output      logic                        inval,
    output      logic                        grant,
    output      logic [pkaf_pkg::LIFE_W-1:0] key_life
);
    timeunit 1ns;
    timeprecision 1ps;
    import pkaf_pkg::*;
    int unsigned      rq;
    int unsigned      kq;
    int unsigned      ct;
    logic             got_c;
    logic             got_r;
    logic [SEQ_W-1:0] sq;
    initial {cmd, reply, reject, perm, inval, grant, key_life} = '0;
    always @(negedge clk) begin
        cmd = 1'b0;
        reject = 1'b0;
        grant = 1'b0;
        inval = send_inval & ~rst;
        reply = {1'b0, ~reply.seq, ~reply.lifetime, ~reply.security_assoc_id};
        perm = ~perm;
        key_life = ~key_life;
        got_c = got_c | tx_cert;
        got_r = got_r | tx_req;
        if (rst) begin
            rq = 0;
            kq = 0;
            ct = 0;
            sq = '0;
        end else begin
            if (send_cmd || ct == 1) begin
                cmd = 1'b1;
                ct = CMD_TMO;
                got_c = 1'b0;
                got_r = 1'b0;
            end else if (ct != 0) begin
                ct = (got_c && got_r) ? 0 : ct - 1;
            end
            if (rq == 1) begin
                if (mode == 2'h1) begin
                    sq = sq + 1'b1;
                    reply = {1'b1, sq, ak_life, SECURITY_ASSOC_ID};
                end
                reject = mode[1];
                perm = mode[0];
            end
            rq = (tx_req && mode != 2'h0) ? DLY : ((rq != 0) ? rq - 1 : 0);
            if (kq == 1 || send_grant) begin
                grant = 1'b1;
                key_life = KLIFE;
            end
            kq = tx_key_req ? DLY : ((kq != 0) ? kq - 1 : 0);
        end
    end
endmodule
`default_nettype wire

// file: test/privacy_key_auth_fsm_tb.sv
// bench for the authorization machine facing an access point model
// assumes shortened timers; stimulus changes on the falling edge
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
    $display("Error t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module privacy_key_auth_fsm_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pkaf_pkg::*;
    localparam int unsigned       RW   = 20;
    localparam logic [SECURITY_ASSOC_ID_W-1:0] SECURITY_ASSOC_ID = 16'h0a5c;
    typedef struct packed { logic [1:0] mode; logic more; logic run; logic sil; } pkaf_row_s;
    localparam pkaf_row_s ROWS [4] = '{'{2'h0, 1'b1, 1'b0, 1'b0}, '{2'h1, 1'b0, 1'b1, 1'b0},
                                      '{2'h2, 1'b1, 1'b0, 1'b0}, '{2'h3, 1'b0, 1'b0, 1'b1}};
    logic              clock = 1'b0;
    logic              reset = 1'b1;
    logic [1:0]        mode = 2'h1;
    logic [LIFE_W-1:0] ak_life = 32'h000000c8;
    logic              go_cmd = 1'b0, go_inval = 1'b0, go_grant = 1'b0;
    logic              rx_cmd, rx_rej, rx_perm, rx_inval, rx_grant;
    logic              tx_cert, tx_req, tx_kreq, child_run, key_usable;
    pkaf_reply_s       rx_reply;
    logic [LIFE_W-1:0] rx_life;
    pkaf_child_ev_s    child_ev;
    logic [SECURITY_ASSOC_ID_W-1:0] child_security_assoc_id;
    logic [SEQ_W-1:0]  key_seq;
    pkaf_state_e       state;
    int                fails = 0, checked = 0, cyc = 0;
    int                n_cert, n_req, n_kreq, n_auth, n_pend, n_comp, n_stop, t_cert, t_req;
    initial forever #10 clock = ~clock;
    pkaf_auth_fsm #(.REPLY_WAIT(RW), .REAUTH_REQ(RW), .LEAD(5)) dut (
        .CLOCK(clock), .RESET(reset), .RX_AUTH_CMD(rx_cmd), .RX_AUTH_REPLY(rx_reply),
        .RX_AUTH_REJECT(rx_rej), .RX_REJECT_PERM(rx_perm), .RX_AUTH_INVALID(rx_inval),
        .RX_KEY_GRANT(rx_grant), .RX_KEY_LIFE(rx_life), .TX_MAKER_CERT(tx_cert),
        .TX_AUTH_REQ(tx_req), .TX_KEY_REQ(tx_kreq), .CHILD_EV(child_ev), .CHILD_RUN(child_run),
        .CHILD_SECURITY_ASSOC_ID(child_security_assoc_id), .KEY_USABLE(key_usable), .KEY_SEQ(key_seq), .STATE(state));
    pkaf_ap_model #(.SECURITY_ASSOC_ID(SECURITY_ASSOC_ID)) ap (
        .clk(clock), .rst(reset), .mode(mode), .ak_life(ak_life), .send_cmd(go_cmd),
        .send_inval(go_inval), .send_grant(go_grant), .tx_cert(tx_cert), .tx_req(tx_req),
        .tx_key_req(tx_kreq), .cmd(rx_cmd), .reply(rx_reply), .reject(rx_rej), .perm(rx_perm),
        .inval(rx_inval), .grant(rx_grant), .key_life(rx_life));
    always @(posedge clock) begin
        cyc++;
        if (tx_cert === 1'b1 && n_cert == 0) t_cert = cyc;
        if (tx_req === 1'b1 && n_req == 0) t_req = cyc;
        n_cert += (tx_cert === 1'b1);
        n_req += (tx_req === 1'b1);
        n_kreq += (tx_kreq === 1'b1);
        n_auth += (child_ev.authorized === 1'b1);
        n_pend += (child_ev.pending === 1'b1);
        n_comp += (child_ev.complete === 1'b1);
        n_stop += (child_ev.stop === 1'b1);
    end
    task automatic report_and_stop();
        if (fails == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic clr();
        {n_cert, n_req, n_kreq, n_auth, n_pend, n_comp, n_stop, t_cert, t_req} = '0;
    endtask
    task automatic send(input logic [2:0] w);
        {go_cmd, go_inval, go_grant} <= w;
        tick(1);
        {go_cmd, go_inval, go_grant} <= 3'h0;
    endtask
    task automatic do_reset();
        reset <= 1'b1;
        tick(2);
        reset <= 1'b0;
        clr();
    endtask
    task automatic wait_st(input pkaf_state_e s);
        int k = 0;
        while (state !== s && k < 200) begin
            tick(1);
            k++;
        end
        `CHK(state, s)
        tick(1);
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        report_and_stop();
    end
    initial begin
        foreach (ROWS[i]) begin
            mode <= ROWS[i].mode;
            do_reset();
            `CHK(state, PKAF_START)
            send(3'h4);
            tick(60);
            `CHK(n_cert, 1)
            `CHK(t_req - t_cert, 1)
            `CHK(n_req >= 2, ROWS[i].more)
            `CHK(child_run, ROWS[i].run)
            `CHK(state === PKAF_SILENT, ROWS[i].sil)
        end
        mode <= 2'h1;
        do_reset();
        send(3'h4);
        wait_st(PKAF_AUTHORIZED);
        `CHK(n_auth, 1)
        `CHK(child_security_assoc_id, SECURITY_ASSOC_ID)
        `CHK(key_seq, 2'h1)
        tick(RW - 3);
        `CHK(key_usable, 1'b0)
        tick(5);
        `CHK(key_usable, 1'b1)
        clr();
        send(3'h4);
        tick(5);
        `CHK(n_cert, 0)
        send(3'h1);
        tick(20);
        `CHK(n_kreq, 0)
        tick(10);
        `CHK(n_kreq, 1)
        ak_life <= 32'h00000028;
        clr();
        send(3'h2);
        tick(3);
        `CHK(state, PKAF_REAUTH)
        `CHK(n_pend, 1)
        wait_st(PKAF_AUTHORIZED);
        `CHK(n_comp, 1)
        `CHK(n_cert, 0)
        clr();
        tick(28);
        `CHK(n_req, 0)
        mode <= 2'h2;
        tick(10);
        `CHK(n_req >= 1, 1'b1)
        tick(30);
        `CHK(n_stop >= 1, 1'b1)
        `CHK(child_run, 1'b0)
        `CHK(n_req >= 2, 1'b1)
        mode <= 2'h1;
        do_reset();
        send(3'h4);
        wait_st(PKAF_AUTHORIZED);
        mode <= 2'h0;
        clr();
        tick(80);
        `CHK(n_req >= 2, 1'b1)
        `CHK(n_cert, 0)
        `CHK(state, PKAF_REAUTH)
        report_and_stop();
    end
endmodule
`undef CHK
`default_nettype wire
